/* File: design/obt_pkg.sv */
// obt_pkg: constants for the octal registered bus transceiver
// assumes: every file of the block imports the whole package
package obt_pkg;

  // data path width and capture stream
  localparam int OBT_W = 8;
  localparam int OBT_CAP_W = 18;
  localparam int OBT_BUF_DEPTH = 2;

  // apb address width and register byte offsets
  localparam int OBT_AW = 8;
  localparam logic [7:0] OBT_CTRL_OFF = 8'h00;
  localparam logic [7:0] OBT_STORE_OFF = 8'h04;
  localparam logic [7:0] OBT_STAT_OFF = 8'h08;

  // control register fields
  localparam int OBT_CTRL_ENN = 0;
  localparam int OBT_CTRL_DIR = 1;
  localparam int OBT_CTRL_SELB = 2;
  localparam int OBT_CTRL_SELA = 3;
  localparam int OBT_CTRL_W = 4;
  localparam logic [3:0] OBT_CTRL_RST = 4'h1;

  // stored data register fields
  localparam int OBT_STORE_A = 0;
  localparam int OBT_STORE_B = 8;

  // status register fields
  localparam int OBT_STAT_AOE = 0;
  localparam int OBT_STAT_BOE = 1;
  localparam int OBT_STAT_ACC = 2;
  localparam int OBT_STAT_VLD = 3;

  // capture stream word fields
  localparam int OBT_CAP_AHIT = 16;
  localparam int OBT_CAP_BHIT = 17;

endpackage

/* File: design/obt_buf2.sv */
// obt_buf2: small shift buffer with valid and ready on both sides
// assumes: one clock, clock enable freezes it, entry 0 is the head
`timescale 1ns/100ps
module obt_buf2
  import obt_pkg::*;
#(
  parameter int W = OBT_CAP_W,
  parameter int DEPTH = OBT_BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  // entries, their valid flags and the registered ready
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic rdy_r;
  logic rdy_nxt;

  // pop shifts toward the head, push fills the first free slot
  always_comb begin
    logic pop;
    logic push;
    logic done;
    pop = vld_r[0] & out_ready;
    push = in_valid & rdy_r;
    done = 1'b0;
    mem_nxt = mem_r;
    vld_nxt = vld_r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_nxt[i] = mem_r[i+1];
        vld_nxt[i] = vld_r[i+1];
      end
      vld_nxt[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++) begin
      // first empty slot after the pop takes the word
      if (push && !done && !vld_nxt[i]) begin
        mem_nxt[i] = in_data;
        vld_nxt[i] = 1'b1;
        done = 1'b1;
      end
    end
    rdy_nxt = ~vld_nxt[DEPTH-1];
  end

  // flags reset to empty and ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_r <= '0;
      rdy_r <= 1'b1;
    end else if (clk_en) begin
      vld_r <= vld_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // entry storage needs no reset, valid flags guard it
  always_ff @(posedge pclk) begin
    if (clk_en) begin
      mem_r <= mem_nxt;
    end
  end

  assign in_ready = rdy_r;
  assign out_valid = vld_r[0];
  assign out_data = mem_r[0];

endmodule // obt_buf2

/* File: design/obt_xcvr.sv */
// obt_xcvr: octal registered bus transceiver with apb control
// assumes: pin inputs synchronous to pclk, capture clocks sampled
`timescale 1ns/100ps
module obt_xcvr
  import obt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [OBT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [OBT_W-1:0] a_in,
  output logic [OBT_W-1:0] a_out,
  output logic a_oe,
  input wire logic [OBT_W-1:0] b_in,
  output logic [OBT_W-1:0] b_out,
  output logic b_oe,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  output logic cap_valid,
  output logic [OBT_CAP_W-1:0] cap_data,
  input wire logic cap_ready,
  output logic cap_accept
);

  // control register and its fields
  logic [OBT_CTRL_W-1:0] ctrl_r;
  logic [OBT_CTRL_W-1:0] ctrl_nxt;
  logic en_n;
  logic dir;
  logic sel_b;
  logic sel_a;

  // apb answer registers
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // capture clock history for edge detection
  logic ab_q_r;
  logic ab_q_nxt;
  logic ba_q_r;
  logic ba_q_nxt;
  logic a_hit;
  logic b_hit;

  // storage registers, fed from port a and port b
  logic [OBT_W-1:0] a_store_r;
  logic [OBT_W-1:0] a_store_nxt;
  logic [OBT_W-1:0] b_store_r;
  logic [OBT_W-1:0] b_store_nxt;

  // pin output registers
  logic [OBT_W-1:0] a_out_r;
  logic [OBT_W-1:0] a_out_nxt;
  logic [OBT_W-1:0] b_out_r;
  logic [OBT_W-1:0] b_out_nxt;
  logic a_oe_r;
  logic a_oe_nxt;
  logic b_oe_r;
  logic b_oe_nxt;

  // capture stream into the buffer
  logic push_valid;
  logic [OBT_CAP_W-1:0] push_word;

  assign en_n = ctrl_r[OBT_CTRL_ENN];
  assign dir = ctrl_r[OBT_CTRL_DIR];
  assign sel_b = ctrl_r[OBT_CTRL_SELB];
  assign sel_a = ctrl_r[OBT_CTRL_SELA];

  // apb slave

  // setup cycle prepares the answer, access edge commits a write
  always_comb begin
    logic acc;
    acc = psel & penable & pready_r;
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & ~penable;
    if (psel && !penable) begin
      // decode in the setup cycle
      prdata_nxt = '0;
      case (paddr)
        OBT_CTRL_OFF: begin
          prdata_nxt[OBT_CTRL_W-1:0] = ctrl_r;
        end
        OBT_STORE_OFF: begin
          prdata_nxt[OBT_STORE_A +: OBT_W] = a_store_r;
          prdata_nxt[OBT_STORE_B +: OBT_W] = b_store_r;
        end
        OBT_STAT_OFF: begin
          prdata_nxt[OBT_STAT_AOE] = a_oe_r;
          prdata_nxt[OBT_STAT_BOE] = b_oe_r;
          prdata_nxt[OBT_STAT_ACC] = cap_accept;
          prdata_nxt[OBT_STAT_VLD] = cap_valid;
        end
        default: begin
          // unmapped address answers with an error
          pslverr_nxt = 1'b1;
        end
      endcase
    end else if (psel && penable && !pready_r) begin
      // hold the error until the access completes
      pslverr_nxt = pslverr_r;
    end
    if (acc && pwrite && paddr == OBT_CTRL_OFF) begin
      // only the control register is writable
      ctrl_nxt = pwdata[OBT_CTRL_W-1:0];
    end
  end

  // apb and control state, isolation after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= OBT_CTRL_RST;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // capture

  // rising edges of the capture clocks, never gated by controls
  assign a_hit = a_to_b_capture_clock & ~ab_q_r;
  assign b_hit = b_to_a_capture_clock & ~ba_q_r;

  // clock history tracks the sampled capture clock pins
  always_comb begin
    ab_q_nxt = a_to_b_capture_clock;
    ba_q_nxt = b_to_a_capture_clock;
  end

  // history starts high so a clock held high is no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_q_r <= 1'b1;
      ba_q_r <= 1'b1;
    end else if (clk_en) begin
      ab_q_r <= ab_q_nxt;
      ba_q_r <= ba_q_nxt;
    end
  end

  // each register loads its own port on its own edge, any mode
  always_comb begin
    a_store_nxt = a_hit ? a_in : a_store_r;
    b_store_nxt = b_hit ? b_in : b_store_r;
  end

  // storage holds unknown data until its first capture edge
  always_ff @(posedge pclk) begin
    if (clk_en) begin
      a_store_r <= a_store_nxt;
      b_store_r <= b_store_nxt;
    end
  end

  // output paths

  // enables from bus enable and direction, data muxed and inverted
  always_comb begin
    a_oe_nxt = ~en_n & ~dir;
    b_oe_nxt = ~en_n & dir;
    // low select passes live data, high passes stored data
    a_out_nxt = ~(sel_a ? b_store_r : b_in);
    b_out_nxt = ~(sel_b ? a_store_r : a_in);
  end

  // registered pins switch once per edge, so no mux glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_out_r <= '0;
      b_out_r <= '0;
      a_oe_r <= 1'b0;
      b_oe_r <= 1'b0;
    end else if (clk_en) begin
      a_out_r <= a_out_nxt;
      b_out_r <= b_out_nxt;
      a_oe_r <= a_oe_nxt;
      b_oe_r <= b_oe_nxt;
    end
  end

  // capture stream

  // every capture cycle offers one word holding both registers
  always_comb begin
    push_valid = a_hit | b_hit;
    push_word = '0;
    push_word[OBT_STORE_A +: OBT_W] = a_store_nxt;
    push_word[OBT_STORE_B +: OBT_W] = b_store_nxt;
    push_word[OBT_CAP_AHIT] = a_hit;
    push_word[OBT_CAP_BHIT] = b_hit;
  end

  // two entry buffer toward the stream reader
  obt_buf2 #(
    .W(OBT_CAP_W),
    .DEPTH(OBT_BUF_DEPTH)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(cap_accept),
    .out_valid(cap_valid),
    .out_data(cap_data),
    .out_ready(cap_ready)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign a_out = a_out_r;
  assign b_out = b_out_r;
  assign a_oe = a_oe_r;
  assign b_oe = b_oe_r;

  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // select rising from live to stored on port a
  sequence s_sel_a_rise;
    clk_en && !sel_a ##1 clk_en && sel_a;
  endsequence

  // capture edge on port a while port a is being driven
  sequence s_cap_while_a_driven;
    clk_en && a_oe_r && a_hit;
  endsequence

  a_one_driver: assert property (
    !(a_oe && b_oe))
    else $error("both ports driven");

  a_a_capture: assert property (
    clk_en && a_hit |=> a_store_r == $past(a_in))
    else $error("port a capture missed");

  a_iso_capture: assert property (
    clk_en && en_n && b_hit |=> b_store_r == $past(b_in))
    else $error("isolation capture of b missed");

  a_ungated_cap: assert property (
    s_cap_while_a_driven |=> a_store_r == $past(a_in))
    else $error("capture gated by output control");

  a_iso_quiet: assert property (
    clk_en && en_n |=> !a_oe && !b_oe)
    else $error("port driven in isolation");

  a_dir_pick: assert property (
    clk_en && !en_n |=> a_oe == !$past(dir) && b_oe == $past(dir))
    else $error("wrong port driven for direction");

  a_live_invert: assert property (
    clk_en && !sel_a && $past(presetn) |=> a_out == ~$past(b_in))
    else $error("live data to a not inverted");

  a_stored_b: assert property (
    clk_en && sel_b |=> b_out == ~$past(a_store_r))
    else $error("stored data to b wrong");

  a_sel_clean: assert property (
    s_sel_a_rise |=> a_out == ~$past(b_store_r) ##1 ($stable(a_out)
      || !clk_en || $past(b_store_r) != $past(b_store_r, 2)
      || $past(!sel_a)))
    else $error("select change disturbed port a");

  a_apb_ready: assert property (
    clk_en && psel && !penable |=> pready ##1 (!pready || !clk_en))
    else $error("apb answer timing wrong");

endmodule // obt_xcvr

/* File: bench/obt_bus_model.sv */
// obt_bus_model: far-side logic on the two parallel ports
// assumes: the bench asks for a value on each port, this model decides
// whether it may be put on the wire
`timescale 1ns/100ps
module obt_bus_model
  import obt_pkg::*;
(
  input wire logic a_oe,
  input wire logic [OBT_W-1:0] a_out,
  input wire logic [OBT_W-1:0] a_req,
  input wire logic b_oe,
  input wire logic [OBT_W-1:0] b_out,
  input wire logic [OBT_W-1:0] b_req,
  output logic [OBT_W-1:0] a_in,
  output logic [OBT_W-1:0] b_in
);
  // far side backs off any port the device drives, wire shows the device
  assign a_in = a_oe ? a_out : a_req;
  assign b_in = b_oe ? b_out : b_req;
endmodule // obt_bus_model

/* File: bench/tb_octal_registered_bus_transceiver.sv */
// tb_octal_registered_bus_transceiver: random control, capture, checks
// assumes: obt_xcvr as top, bus model on ports, 125 MHz clock
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_octal_registered_bus_transceiver
  import obt_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, a_req = 0, b_req = 0, a_in, b_in, a_out, b_out;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, a_oe, b_oe, cap_valid, cap_accept, er;
  logic cab = 0, cba = 0, cap_ready = 0;
  logic [17:0] cap_data;
  logic [17:0] q[$];
  logic [17:0] exp_w;
  logic [7:0] areg, breg, aw, bw, ae, be;
  logic [3:0] c;
  logic ca, cb, aoe_e, boe_e;
  int err_total = 0, n_tests = 0, cyc = 0, seed = 32'h51012432;
  // clock: 8 ns period
  always #4 pclk = ~pclk;
  obt_xcvr dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out),
    .b_oe(b_oe), .a_to_b_capture_clock(cab), .b_to_a_capture_clock(cba),
    .cap_valid(cap_valid), .cap_data(cap_data), .cap_ready(cap_ready),
    .cap_accept(cap_accept));
  obt_bus_model far (.a_oe(a_oe), .a_out(a_out), .a_req(a_req),
    .b_oe(b_oe), .b_out(b_out), .b_req(b_req), .a_in(a_in), .b_in(b_in));
  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // reader side: every word taken must match the model queue
  always @(posedge pclk) begin
    if (cap_valid === 1'b1 && cap_ready) begin
      // pop once, the compare macro names its operands twice
      exp_w = q.pop_front();
      `CHK(cap_data, exp_w)
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    `CHK({a_oe, b_oe, cap_valid, cap_accept}, 4'h1)
    presetn <= 1;
    apb(0, OBT_CTRL_OFF, 0);
    `CHK(rd[3:0], OBT_CTRL_RST)
    for (int i = 0; i < 15; i++) begin
      c = $random(seed);
      // stored paths stay off until the first capture fills both registers
      if (i == 0) c[3:2] = 2'b00;
      a_req <= $random(seed);
      b_req <= $random(seed);
      ca = (i == 0) | $random(seed);
      cb = (i == 0) | $random(seed);
      apb(1, OBT_CTRL_OFF, {28'h0, c});
      repeat (4) @(posedge pclk);
      aoe_e = !c[0] && !c[1];
      boe_e = !c[0] && c[1];
      bw = b_req;
      ae = ~(c[3] ? breg : bw);
      aw = aoe_e ? ae : a_req;
      be = ~(c[2] ? areg : aw);
      if (boe_e) bw = be;
      ae = ~(c[3] ? breg : bw);
      `CHK({a_oe, b_oe}, {aoe_e, boe_e})
      `CHK({a_out, b_out}, {ae, be})
      @(posedge pclk);
      cab <= ca;
      cba <= cb;
      @(posedge pclk);
      cab <= 0;
      cba <= 0;
      if (ca) areg = aw;
      if (cb) breg = bw;
      `CHK(cap_accept, 1'(q.size() < 2))
      if ((ca || cb) && q.size() < 2) q.push_back({cb, ca, breg, areg});
      repeat (3) @(posedge pclk);
      apb(0, OBT_STORE_OFF, 0);
      `CHK(rd[15:0], {breg, areg})
      if (i % 3 == 2) begin
        cap_ready <= 1;
        repeat (4) @(posedge pclk);
        cap_ready <= 0;
        `CHK(q.size(), 0)
      end
    end
    apb(0, OBT_STAT_OFF, 0);
    `CHK(rd[1:0], {boe_e, aoe_e})
    apb(0, 8'h0C, 0);
    `CHK({er, rd}, {1'b1, 32'h0})
    wrap_up();
  end
endmodule // tb_octal_registered_bus_transceiver
